// ### include/mcs_link_if.sv
// interface: coded serial bus wires between codec and bitstream partner
`timescale 1ns/1ps
interface mcs_link_if;
    logic bclk_dev_o, bclk_dev_oe, bclk_ext_o, bclk_ext_oe;
    logic ws_dev_o,   ws_dev_oe,   ws_ext_o,   ws_ext_oe;
    logic sd_dev_o,   sd_dev_oe,   sd_ext_o,   sd_ext_oe;
    logic coded_bit_clock;
    logic coded_word_select;
    logic coded_serial_data;
    logic coded_byte_error_flag;
    logic coded_bus_direction;
    logic codec_direction;
    // resolved wire levels, pull-down when nobody drives
    assign coded_bit_clock   = bclk_dev_oe ? bclk_dev_o : (bclk_ext_oe ? bclk_ext_o : 1'b0);
    assign coded_word_select = ws_dev_oe   ? ws_dev_o   : (ws_ext_oe   ? ws_ext_o   : 1'b0);
    assign coded_serial_data = sd_dev_oe   ? sd_dev_o   : (sd_ext_oe   ? sd_ext_o   : 1'b0);

    modport dev (
        output bclk_dev_o, bclk_dev_oe, ws_dev_o, ws_dev_oe, sd_dev_o, sd_dev_oe,
        output codec_direction,
        input  coded_bit_clock, coded_word_select, coded_serial_data,
        input  coded_byte_error_flag, coded_bus_direction
    );
    modport ext (
        output bclk_ext_o, bclk_ext_oe, ws_ext_o, ws_ext_oe, sd_ext_o, sd_ext_oe,
        output coded_byte_error_flag, coded_bus_direction,
        input  coded_bit_clock, coded_word_select, coded_serial_data, codec_direction
    );
endinterface

// ### include/mcs_pkg.sv
// package: constants and types for the coded sub-band serial port
package mcs_pkg;
    // =========================================================
    // slot framing
    localparam int unsigned BITS_PER_WS   = 64;
    localparam int unsigned PAYLOAD_BITS  = 32;
    localparam int unsigned HALF_BITS     = 16;
    localparam logic [5:0]  POS_MAX       = 6'h3F;
    localparam logic [5:0]  POS_HIGH_HALF = 6'h20;
    localparam logic [5:0]  POS_FIRST_BIT = 6'h01;
    localparam logic [5:0]  POS_LAST_LOW  = 6'h10;
    localparam logic [5:0]  POS_LAST_HIGH = 6'h30;
    // =========================================================
    // timing, clock 250 MHz
    localparam int unsigned CLK_PERIOD_PS    = 4000;
    localparam int unsigned RST_TO_SYNC_NS   = 300;
    localparam int unsigned SYNC_HIGH_NS     = 1280;
    localparam int unsigned SYNC_TO_REL_NS   = 790;
    localparam int unsigned RST_TO_SYNC_CYC  = (RST_TO_SYNC_NS * 1000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
    localparam int unsigned SYNC_HIGH_CYC    = (SYNC_HIGH_NS * 1000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
    localparam int unsigned SYNC_TO_REL_CYC  = (SYNC_TO_REL_NS * 1000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
    localparam int unsigned SEQ_CNT_W        = 9;
    // master clock divider: half period of the bit clock in core cycles
    localparam logic [7:0]  BCLK_HALF_DEF    = 8'h08;
    // bit rate codes, kbit/s
    localparam logic [8:0]  RATE_384 = 9'h180;
    localparam logic [8:0]  RATE_256 = 9'h100;
    localparam logic [8:0]  RATE_192 = 9'h0C0;
    localparam logic [8:0]  RATE_128 = 9'h080;
    localparam logic [8:0]  RATE_448 = 9'h1C0;
    localparam logic [8:0]  RATE_32  = 9'h020;
    // =========================================================
    // types
    typedef enum logic [1:0] {
        MCS_SEQ_IDLE  = 2'b00,
        MCS_SEQ_LEAD  = 2'b01,
        MCS_SEQ_PULSE = 2'b11,
        MCS_SEQ_TAIL  = 2'b10
    } mcs_seq_t;

    function automatic logic mcs_rate_ok(input logic decode, input logic [8:0] rate);
        if (decode)
            mcs_rate_ok = (rate >= RATE_32) && (rate <= RATE_448);
        else
            mcs_rate_ok = (rate == RATE_384) || (rate == RATE_256) ||
                          (rate == RATE_192) || (rate == RATE_128);
    endfunction
endpackage

// ### logic/mcs_codec_port.sv
// codec end of the coded sub-band serial port
`timescale 1ns/1ps
module mcs_codec_port
    import mcs_pkg::*;
(
    input  wire logic        core_clk,               // core clock
    input  wire logic        reset,                  // async reset
    mcs_link_if.dev          link,                   // coded serial bus
    input  wire logic        decode_mode,            // 1 decode, 0 encode
    input  wire logic [8:0]  bit_rate,               // kbit/s
    input  wire logic [7:0]  bclk_half,              // master clocks per half bit clock
    input  wire logic [31:0] tx_slot,                // slot to send
    input  wire logic        tx_valid,               // slot offered
    output logic             tx_ready,               // slot taken
    output logic [31:0]      rx_slot,                // received slot
    output logic [3:0]       rx_byte_err,            // per-byte error flags
    output logic             rx_valid,               // received slot valid
    input  wire logic        rx_ready,               // consumer ready
    output logic             rate_ok,                // rate legal in mode
    output logic             companion_reset_request,// companion reset
    output logic             io_sync_pulse           // io sync
);
    import mcs_pkg::*;

    // =========================================================
    // mode, rate change detect and control sequence
    logic        dir_reg;
    logic [8:0]  rate_reg;
    logic        boot_reg;
    mcs_seq_t    seq_reg;
    logic [SEQ_CNT_W-1:0] seq_cnt_reg;
    logic        companion_reset_request_reg, sync_reg;
    wire         change  = (decode_mode != dir_reg) || (bit_rate != rate_reg) || boot_reg;
    wire         seq_act = (seq_reg != MCS_SEQ_IDLE);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dir_reg  <= 1'b0;
            rate_reg <= 9'h000;
            boot_reg <= 1'b1;
            rate_ok  <= 1'b0;
        end else begin
            dir_reg  <= decode_mode;
            rate_reg <= bit_rate;
            boot_reg <= 1'b0;
            rate_ok  <= mcs_rate_ok(decode_mode, bit_rate);
        end
    end
    assign link.codec_direction = dir_reg;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            seq_reg     <= MCS_SEQ_LEAD;
            seq_cnt_reg <= '0;
            companion_reset_request_reg  <= 1'b1;
            sync_reg    <= 1'b0;
        end else begin
            seq_cnt_reg <= seq_cnt_reg + 1'b1;
            unique case (seq_reg)
                MCS_SEQ_IDLE: begin
                    seq_cnt_reg <= '0;
                    if (change) begin
                        seq_reg    <= MCS_SEQ_LEAD;
                        companion_reset_request_reg <= 1'b1;
                    end
                end
                MCS_SEQ_LEAD: if (seq_cnt_reg == SEQ_CNT_W'(RST_TO_SYNC_CYC - 1)) begin
                    seq_reg     <= MCS_SEQ_PULSE;
                    sync_reg    <= 1'b1;
                    seq_cnt_reg <= '0;
                end
                MCS_SEQ_PULSE: if (seq_cnt_reg == SEQ_CNT_W'(SYNC_HIGH_CYC - 1)) begin
                    seq_reg     <= MCS_SEQ_TAIL;
                    sync_reg    <= 1'b0;
                    seq_cnt_reg <= '0;
                end
                MCS_SEQ_TAIL: if (seq_cnt_reg == SEQ_CNT_W'(SYNC_TO_REL_CYC - 1)) begin
                    seq_reg    <= MCS_SEQ_IDLE;
                    companion_reset_request_reg <= 1'b0;
                end
            endcase
        end
    end
    assign companion_reset_request = companion_reset_request_reg;
    assign io_sync_pulse           = sync_reg;

    // =========================================================
    // bit clock generator from the master clock
    logic [7:0] div_reg;
    logic       bclk_reg, ws_reg, sd_reg;
    logic [5:0] tx_pos_reg;
    logic [31:0] sh_reg;
    wire        div_wrap = (div_reg == 8'h00);
    wire        bclk_fall = div_wrap && bclk_reg;
    wire        drive    = !dir_reg && !link.coded_bus_direction && !seq_act;
    wire        nxt_pos_last = (tx_pos_reg == POS_MAX);
    wire [5:0]  tx_pos_nx = tx_pos_reg + 6'h01;
    wire        bit_slot = (tx_pos_nx >= POS_FIRST_BIT && tx_pos_nx <= POS_LAST_LOW) ||
                           (tx_pos_nx >  POS_HIGH_HALF && tx_pos_nx <= POS_LAST_HIGH);
    wire [31:0] tx_head;
    wire        tx_head_v;
    wire        tx_take = bclk_fall && drive && (tx_pos_reg == POS_MAX) && tx_head_v;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            div_reg    <= 8'h00;
            bclk_reg   <= 1'b0;
            ws_reg     <= 1'b0;
            sd_reg     <= 1'b0;
            tx_pos_reg <= POS_MAX;
            sh_reg     <= 32'h0000_0000;
        end else begin
            div_reg <= div_wrap ? bclk_half - 8'h01 : div_reg - 8'h01;
            if (div_wrap)
                bclk_reg <= ~bclk_reg;
            if (!drive) begin
                tx_pos_reg <= POS_MAX;
                ws_reg     <= 1'b1; // first slot opens on a visible ws fall
            end else if (bclk_fall) begin
                tx_pos_reg <= tx_pos_nx;
                ws_reg     <= tx_pos_nx[5];
                if (nxt_pos_last)
                    sh_reg <= tx_head_v ? tx_head : 32'h0000_0000;
                else if (bit_slot)
                    sh_reg <= {1'b0, sh_reg[31:1]};
                sd_reg <= bit_slot ? (nxt_pos_last ? 1'b0 : sh_reg[0]) : 1'b0;
            end
        end
    end

    mcs_skid_buf #(.WIDTH(32)) u_tx_buf (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_data   (tx_slot),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (tx_head),
        .out_valid (tx_head_v),
        .out_ready (tx_take)
    );

    assign link.bclk_dev_o  = bclk_reg;
    assign link.ws_dev_o    = ws_reg;
    assign link.sd_dev_o    = sd_reg;
    assign link.bclk_dev_oe = drive;
    assign link.ws_dev_oe   = drive;
    assign link.sd_dev_oe   = drive;

    // =========================================================
    // decode receiver, sampled on core clock
    logic       cl_d_reg, ws_d_reg;
    logic [5:0] rx_pos_reg;
    logic [31:0] rsh_reg;
    logic [3:0]  ef_reg;
    logic        rx_push_reg;
    logic        rx_sync_reg;
    wire         rx_en    = dir_reg && link.coded_bus_direction && !seq_act;
    wire         cl_rise  = link.coded_bit_clock && !cl_d_reg;
    wire         ws_edge  = link.coded_word_select != ws_d_reg;
    wire [5:0]   rx_pos   = ws_edge ? {link.coded_word_select, 5'h00} : rx_pos_reg + 6'h01;
    wire [4:0]   rx_idx   = {rx_pos[5], rx_pos[3:0] - 4'h1};
    wire         rx_bit   = rx_pos[4] == 1'b0 && rx_pos[3:0] != 4'h0 ||
                            rx_pos == POS_LAST_LOW || rx_pos == POS_LAST_HIGH;
    wire [4:0]   rx_idx_f = (rx_pos[4] ? {rx_pos[5], 4'hF} : rx_idx);
    wire         rx_half  = rx_idx_f[2:0] == 3'h3; // flag rides with bit 3 of a byte
    wire [31:0]  rx_word;
    wire [3:0]   rx_err;
    wire         rx_in_ready;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cl_d_reg    <= 1'b0;
            ws_d_reg    <= 1'b0;
            rx_pos_reg  <= 6'h00;
            rsh_reg     <= 32'h0000_0000;
            ef_reg      <= 4'h0;
            rx_push_reg <= 1'b0;
            rx_sync_reg <= 1'b0;
        end else begin
            cl_d_reg <= link.coded_bit_clock;
            if (rx_in_ready || !rx_push_reg)
                rx_push_reg <= 1'b0;
            if (!rx_en) begin
                ws_d_reg    <= link.coded_word_select;
                rx_sync_reg <= 1'b0;
            end else if (cl_rise) begin
                ws_d_reg   <= link.coded_word_select;
                rx_pos_reg <= rx_pos;
                if (ws_edge && !link.coded_word_select)
                    rx_sync_reg <= 1'b1; // only whole slots after a ws fall
                if (rx_bit)
                    rsh_reg[rx_idx_f] <= link.coded_serial_data;
                if (rx_bit && rx_half)
                    ef_reg[rx_idx_f[4:3]] <= link.coded_byte_error_flag;
                if (rx_pos == POS_LAST_HIGH && rx_sync_reg)
                    rx_push_reg <= 1'b1;
            end
        end
    end

    mcs_skid_buf #(.WIDTH(36)) u_rx_buf (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_data   ({ef_reg, rsh_reg}),
        .in_valid  (rx_push_reg),
        .in_ready  (rx_in_ready),
        .out_data  ({rx_err, rx_word}),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );
    assign rx_slot     = rx_word;
    assign rx_byte_err = rx_err;
endmodule // mcs_codec_port

// ### logic/mcs_skid_buf.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module mcs_skid_buf #(
    parameter int unsigned WIDTH = 32
) (
    input  wire logic             core_clk,   // clock
    input  wire logic             reset,      // async reset
    input  wire logic [WIDTH-1:0] in_data,    // fill data
    input  wire logic             in_valid,   // fill valid
    output logic                  in_ready,   // room available
    output logic [WIDTH-1:0]      out_data,   // head word
    output logic                  out_valid,  // head valid
    input  wire logic             out_ready   // drain accepts
);
    logic [WIDTH-1:0] mem_reg [2];
    logic             rd_reg, wr_reg;
    logic [1:0]       cnt_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data  = mem_reg[rd_reg];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rd_reg  <= 1'b0;
            wr_reg  <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            if (push)
                wr_reg <= ~wr_reg;
            if (pop)
                rd_reg <= ~rd_reg;
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge core_clk) begin
        if (push)
            mem_reg[wr_reg] <= in_data;
    end
endmodule // mcs_skid_buf

// ### logic/mcs_stream_end.sv
// bitstream partner end: drives the bus when the codec decodes
`timescale 1ns/1ps
module mcs_stream_end
    import mcs_pkg::*;
(
    input  wire logic        core_clk,    // core clock
    input  wire logic        reset,       // async reset
    mcs_link_if.ext          link,        // coded serial bus
    input  wire logic [7:0]  bclk_half,   // core clocks per half bit clock
    input  wire logic [31:0] src_slot,    // slot to send
    input  wire logic [3:0]  src_err,     // per-byte error flags
    input  wire logic        src_valid,   // slot offered
    output logic             src_ready    // slot taken
);
    import mcs_pkg::*;

    logic [7:0]  div_reg;
    logic        bclk_reg, ws_reg, sd_reg, ef_reg, dir_reg;
    logic [5:0]  pos_reg;
    logic [31:0] sh_reg;
    logic [3:0]  er_reg;
    wire         dec     = link.codec_direction;
    wire         div_wrap = (div_reg == 8'h00);
    wire         fall    = div_wrap && bclk_reg;
    wire [5:0]   pos_nx  = pos_reg + 6'h01;
    wire         bit_slot = (pos_nx >= POS_FIRST_BIT && pos_nx <= POS_LAST_LOW) ||
                            (pos_nx >  POS_HIGH_HALF && pos_nx <= POS_LAST_HIGH);
    wire [4:0]   idx     = {pos_nx[5], pos_nx[3:0] - 4'h1};
    wire         last    = (pos_nx == POS_MAX);
    assign src_ready = dec && fall && last;

    // drive direction high always, never low while decoding
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            div_reg  <= 8'h00;
            bclk_reg <= 1'b0;
            ws_reg   <= 1'b0;
            sd_reg   <= 1'b0;
            ef_reg   <= 1'b0;
            dir_reg  <= 1'b1;
            pos_reg  <= POS_MAX;
            sh_reg   <= 32'h0000_0000;
            er_reg   <= 4'h0;
        end else begin
            dir_reg <= 1'b1;
            div_reg <= div_wrap ? bclk_half - 8'h01 : div_reg - 8'h01;
            if (div_wrap)
                bclk_reg <= ~bclk_reg;
            if (!dec) begin
                pos_reg <= POS_MAX;
                ws_reg  <= 1'b0; // idle at the pull-down level
                sd_reg  <= 1'b0;
                ef_reg  <= 1'b0;
            end else if (fall) begin
                pos_reg <= pos_nx;
                ws_reg  <= pos_nx[5];
                if (last) begin
                    sh_reg <= src_valid ? src_slot : 32'h0000_0000;
                    er_reg <= src_valid ? src_err : 4'h0;
                end
                sd_reg <= bit_slot ? sh_reg[idx] : 1'b0;
                ef_reg <= bit_slot && (idx[2:0] == 3'h3) ? er_reg[idx[4:3]] : 1'b0;
            end
        end
    end

    assign link.bclk_ext_o  = bclk_reg;
    assign link.ws_ext_o    = ws_reg;
    assign link.sd_ext_o    = sd_reg;
    assign link.bclk_ext_oe = dec;
    assign link.ws_ext_oe   = dec;
    assign link.sd_ext_oe   = dec;
    assign link.coded_byte_error_flag = ef_reg;
    assign link.coded_bus_direction   = dir_reg;
endmodule // mcs_stream_end

// ### test/mcs_link_sva.sv
// checker: timing relations on the coded serial bus
`timescale 1ns/1ps
module mcs_link_sva (
    input wire logic core_clk,              // core clock
    input wire logic reset,                 // async reset
    input wire logic coded_bit_clock,       // bus bit clock
    input wire logic coded_word_select,     // bus word select
    input wire logic coded_serial_data,     // bus data
    input wire logic coded_byte_error_flag, // byte error flag
    input wire logic coded_bus_direction,   // bus direction
    input wire logic codec_direction,       // codec mode
    input wire logic bclk_dev_oe,           // codec clock drive
    input wire logic ws_dev_oe,             // codec select drive
    input wire logic sd_dev_oe              // codec data drive
);
    // ==========================================================
    // bit clock rises since the last word select change
    logic [6:0] rise_cnt_reg;
    logic       seen_reg;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rise_cnt_reg <= 7'h00;
            seen_reg     <= 1'b0;
        end else if (!codec_direction) begin
            rise_cnt_reg <= 7'h00;
            seen_reg     <= 1'b0;
        end else if ($changed(coded_word_select)) begin
            rise_cnt_reg <= 7'h00;
            seen_reg     <= 1'b1;
        end else if ($rose(coded_bit_clock)) begin
            rise_cnt_reg <= rise_cnt_reg + 7'h01;
        end
    end
    // ==========================================================
    // assertions
    property p_ws_fall;
        $changed(coded_word_select) |-> !coded_bit_clock;
    endproperty
    a_ws_fall: assert property (p_ws_fall)
        else $error("word select moved with bit clock high");
    property p_sd_fall;
        $changed(coded_serial_data) |-> !coded_bit_clock;
    endproperty
    a_sd_fall: assert property (p_sd_fall)
        else $error("data moved with bit clock high");
    property p_half_len;
        $changed(coded_word_select) && seen_reg && codec_direction |-> rise_cnt_reg == 7'h20;
    endproperty
    a_half_len: assert property (p_half_len)
        else $error("word select half not 32 bit clocks");
    property p_flag_mid;
        coded_byte_error_flag |-> rise_cnt_reg inside {[7'h02:7'h06], [7'h0A:7'h0E]};
    endproperty
    a_flag_mid: assert property (p_flag_mid)
        else $error("byte flag away from mid byte");
    // bench runs half period of 3 core cycles
    property p_bclk_min;
        $changed(coded_bit_clock) && $past(codec_direction) |=>
            (!codec_direction || $stable(coded_bit_clock))[*2];
    endproperty
    a_bclk_min: assert property (p_bclk_min)
        else $error("bit clock half period too short");
    property p_dir_off;
        coded_bus_direction && $past(coded_bus_direction) |-> !bclk_dev_oe;
    endproperty
    a_dir_off: assert property (p_dir_off)
        else $error("codec drives clock while direction high");
    property p_dev_quiet;
        coded_bus_direction ##1 coded_bus_direction |-> !ws_dev_oe && !sd_dev_oe;
    endproperty
    a_dev_quiet: assert property (p_dev_quiet)
        else $error("codec drives select or data while direction high");
    property p_dir_hold;
        codec_direction && $past(codec_direction) |-> coded_bus_direction;
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("direction low while decoding");
endmodule // mcs_link_sva

// ### test/mpeg_coded_subband_serial_port_test.sv
// testbench: both ends of the coded serial port with a queue model
`timescale 1ns/1ps
module mpeg_coded_subband_serial_port_test;
    import mcs_pkg::*;
    logic        core_clk, reset, mode1, src_valid, tx_valid, rx_ready, flag2, ignore;
    logic        src_ready, tx_ready, rx_valid1, ok1, ok2, req1, sync1, took1, took2;
    logic        ws2_prev, armed, prev_req, prev_sync;
    logic [8:0]  rate;
    logic [31:0] src_slot, tx_slot, rx_slot1, seed, asm2;
    logic [3:0]  src_err, rx_err1;
    logic [35:0] q1[$];
    logic [31:0] q2[$];
    logic [8:0]  rates[10] = '{RATE_256, RATE_192, RATE_128, RATE_448, RATE_32,
                               9'h040, 9'h010, 9'h1E0, 9'h140, RATE_384};
    int          fail_count, n_tests, n_rx1, n_rx2, pos2, lead, pulse, tail, i, r;
    mcs_link_if link ();
    mcs_link_if link2 ();
    // ==========================================================
    // ends, far side of the second link held by the bench
    mcs_codec_port mcs_codec_port_inst (.core_clk(core_clk), .reset(reset), .link(link),
        .decode_mode(mode1), .bit_rate(rate), .bclk_half(8'h03), .tx_slot(tx_slot),
        .tx_valid(1'b0), .tx_ready(), .rx_slot(rx_slot1), .rx_byte_err(rx_err1),
        .rx_valid(rx_valid1), .rx_ready(rx_ready), .rate_ok(ok1),
        .companion_reset_request(req1), .io_sync_pulse(sync1));
    mcs_stream_end mcs_stream_end_inst (.core_clk(core_clk), .reset(reset), .link(link),
        .bclk_half(8'h03), .src_slot(src_slot), .src_err(src_err),
        .src_valid(src_valid), .src_ready(src_ready));
    mcs_codec_port mcs_codec_port_inst2 (.core_clk(core_clk), .reset(reset), .link(link2),
        .decode_mode(1'b0), .bit_rate(rate), .bclk_half(8'h03), .tx_slot(tx_slot),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_slot(), .rx_byte_err(),
        .rx_valid(), .rx_ready(rx_ready), .rate_ok(ok2),
        .companion_reset_request(), .io_sync_pulse());
    assign link2.bclk_ext_o = 1'b0;
    assign link2.bclk_ext_oe = 1'b0;
    assign link2.ws_ext_o = 1'b0;
    assign link2.ws_ext_oe = 1'b0;
    assign link2.sd_ext_o = 1'b0;
    assign link2.sd_ext_oe = 1'b0;
    assign link2.coded_bus_direction = 1'b0;
    assign link2.coded_byte_error_flag = flag2;
    mcs_link_sva mcs_link_sva_inst (.core_clk(core_clk), .reset(reset),
        .coded_bit_clock(link.coded_bit_clock), .coded_word_select(link.coded_word_select),
        .coded_serial_data(link.coded_serial_data),
        .coded_byte_error_flag(link.coded_byte_error_flag),
        .coded_bus_direction(link.coded_bus_direction),
        .codec_direction(link.codec_direction), .bclk_dev_oe(link.bclk_dev_oe),
        .ws_dev_oe(link.ws_dev_oe), .sd_dev_oe(link.sd_dev_oe));
    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk_word(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: slot %h expected %h", $time, got, exp);
        end
    endtask
    task chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task results;
        $display("counts: %0d checks, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task wait_seq;
        for (i = 0; i < 2000 && req1 !== 1'b0; i++) @(negedge core_clk);
        chk_bit(req1, 1'b0);
        if (req1 !== 1'b0) results();
    endtask
    task drain;
        for (i = 0; i < 4000 && q1.size() != 0; i++) @(negedge core_clk);
        chk_bit(q1.size() == 0, 1'b1);
        if (q1.size() != 0) results();
    endtask
    // ==========================================================
    // stimulus, model and monitors
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (100000) @(posedge core_clk);
        fail_count++;
        $display("unexpected at %0t: run timeout", $time);
        results();
    end
    always @(posedge core_clk) begin
        took1 <= src_valid && src_ready;
        took2 <= tx_valid && tx_ready;
        if (!reset && rx_valid1 && rx_ready) begin
            n_rx1++;
            chk_bit(ignore, 1'b0);
            // an idle slot of the partner arrives as zeros
            if (!ignore)
                chk_word({rx_err1, rx_slot1}, q1.size() ? q1.pop_front() : '0);
        end
        if (prev_sync && !sync1) chk_bit(pulse >= SYNC_HIGH_CYC, 1'b1);
        if (!prev_sync && sync1) chk_bit(lead >= RST_TO_SYNC_CYC, 1'b1);
        if (prev_req && !req1) chk_bit(tail >= SYNC_TO_REL_CYC, 1'b1);
        if (!req1) {lead, pulse, tail} = '0;
        else if (sync1) pulse++;
        else if (pulse == 0) lead++;
        else tail++;
        prev_req = req1;
        prev_sync = sync1;
    end
    always @(negedge core_clk) begin
        seed = lfsr(seed);
        rx_ready <= seed[0] | seed[1];
        flag2 <= seed[2];
        if (took1) begin
            if (!ignore) q1.push_back({src_err, src_slot});
            src_slot <= seed;
            src_err <= seed[7:4];
        end
        if (took2) begin
            q2.push_back(tx_slot);
            tx_slot <= {seed[15:0], seed[31:16]};
        end
    end
    // rebuild slots sent by the encoding codec
    always @(posedge link2.coded_bit_clock) begin
        pos2 = (link2.coded_word_select !== ws2_prev) ? 0 : pos2 + 1;
        ws2_prev = link2.coded_word_select;
        if (pos2 == 0 && !ws2_prev) armed = 1'b1;
        if (pos2 >= 1 && pos2 <= 16) asm2[(ws2_prev ? 16 : 0) + pos2 - 1] = link2.coded_serial_data;
        if (armed && ws2_prev && pos2 == 16 && q2.size() != 0) begin
            n_rx2++;
            chk_word({4'h0, asm2}, {4'h0, q2.pop_front()});
        end
    end
    initial begin
        seed = 32'hCF17D9DA;
        {reset, mode1} = 2'b11;
        {src_valid, tx_valid, rx_ready, flag2, ignore, took1, took2, armed, ws2_prev} = '0;
        {fail_count, n_tests, n_rx1, n_rx2, pos2, lead, pulse, tail} = '0;
        rate = RATE_384;
        src_slot = 32'h0;
        src_err = 4'h0;
        tx_slot = 32'h0;
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        wait_seq();
        chk_bit(link.codec_direction, 1'b1);
        chk_bit(link2.codec_direction, 1'b0);
        {src_valid, tx_valid} = 2'b11;
        repeat (4000) @(negedge core_clk);
        {src_valid, tx_valid} = 2'b00;
        drain();
        chk_bit(n_rx1 >= 6, 1'b1);
        chk_bit(n_rx2 >= 6, 1'b1);
        $display("test traffic done");
        mode1 = 1'b0;
        repeat (4) @(negedge core_clk);
        chk_bit(req1, 1'b1);
        wait_seq();
        ignore = 1'b1;
        chk_bit(link.codec_direction, 1'b0);
        src_valid = 1'b1;
        repeat (1500) @(negedge core_clk);
        src_valid = 1'b0;
        repeat (1600) @(negedge core_clk);
        mode1 = 1'b1;
        repeat (4) @(negedge core_clk);
        wait_seq();
        {ignore, n_rx1} = '0;
        src_valid = 1'b1;
        repeat (2000) @(negedge core_clk);
        src_valid = 1'b0;
        drain();
        chk_bit(n_rx1 >= 3, 1'b1);
        $display("test mode change done");
        for (int k = 0; k < 10; k++) begin
            rate = rates[k];
            r = rates[k];
            repeat (4) @(negedge core_clk);
            chk_bit(req1, 1'b1);
            chk_bit(ok1, r >= 32 && r <= 448);
            chk_bit(ok2, r == 384 || r == 256 || r == 192 || r == 128);
            wait_seq();
        end
        $display("test rates done");
        results();
    end
endmodule // mpeg_coded_subband_serial_port_test
